// ---- rtl/pdc_converter.sv ----
// pixel depth converter: 16-bit to 18-bit pixel lookup with bus slave and mode control
`timescale 1ns/1ps
`include "pdc_defines.svh"

module pdc_converter
    import pdc_pkg::*;
#(
    parameter int DATA_W = 6,
    parameter int DEPTH = 128,
    parameter int ADDR_W = 7,
    parameter logic [7:0] REVISION = `PDC_REVISION
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // bus slave
    input wire pdc_ocp_req_t ocp_req,
    output logic [7:0] sdata_out,
    output logic scmdaccept,
    output logic [1:0] sresp,
    // pixel path
    input wire logic [15:0] pixel_in,
    input wire logic frame_sync_in,
    output logic [15:0] pixel_out,
    output logic red_lsb,
    output logic blue_lsb
);
    localparam int LANES = 3;
    localparam int LANE_RED = 0;
    localparam int LANE_GREEN = 1;
    localparam int LANE_BLUE = 2;

    pdc_bus_state_t bus_state_reg, bus_state_next;
    pdc_ctrl_t ctrl_reg, ctrl_next;
    logic [7:0] sdata_reg, sdata_next;
    logic [1:0] sresp_reg, sresp_next;
    logic fs_s1_reg, fs_s1_next;
    logic fs_s2_reg, fs_s2_next;

    logic cmd_rd;
    logic cmd_wr;
    logic cmd_valid;
    logic is_table;
    logic is_ctrl;
    logic is_rev;
    logic host_we;
    logic [7:0] read_mux;
    logic sync_rise;
    logic sync_fall;
    logic edge_hit;
    logic [DATA_W-1:0] host_rdata;
    logic [LANES-1:0][ADDR_W-1:0] pix_addr;
    logic [LANES-1:0][DATA_W-1:0] pix_rdata;
    logic [DATA_W-1:0] red_word;
    logic [DATA_W-1:0] green_word;
    logic [DATA_W-1:0] blue_word;

    // command decode; any other code is treated as idle
    assign cmd_rd = (ocp_req.mcmd == `PDC_CMD_RD);
    assign cmd_wr = (ocp_req.mcmd == `PDC_CMD_WR);
    assign cmd_valid = cmd_rd | cmd_wr;
    assign is_table = ~ocp_req.maddr[`PDC_TABLE_SEL_BIT];
    assign is_ctrl = (ocp_req.maddr == `PDC_CTRL_ADDR);
    assign is_rev = (ocp_req.maddr == `PDC_REV_ADDR);

    // writes reach the table only in 16-bit mode and only the low six bits
    assign host_we = scmdaccept & cmd_wr & is_table & ~ctrl_reg.mode_status;

    // frame sync edge from two successive samples
    assign sync_rise = fs_s1_reg & ~fs_s2_reg;
    assign sync_fall = ~fs_s1_reg & fs_s2_reg;
    assign edge_hit = ctrl_reg.frame_sync_polarity ? sync_fall : sync_rise;

    // pixel indices into the three tables
    assign pix_addr[LANE_RED] =
        `PDC_RED_BASE | {2'h0, pixel_in[`PDC_RED_HI:`PDC_RED_LO]};
    assign pix_addr[LANE_GREEN] =
        `PDC_GREEN_BASE | {1'h0, pixel_in[`PDC_GREEN_HI:`PDC_GREEN_LO]};
    assign pix_addr[LANE_BLUE] =
        `PDC_BLUE_BASE | {2'h0, pixel_in[`PDC_BLUE_HI:`PDC_BLUE_LO]};

    assign red_word = pix_rdata[LANE_RED];
    assign green_word = pix_rdata[LANE_GREEN];
    assign blue_word = pix_rdata[LANE_BLUE];

    // the host port and the three pixel lanes share one memory; the host port decodes straight off addr[6:0]
    pdc_lut_mem #(
        .DATA_W(DATA_W),
        .DEPTH(DEPTH),
        .ADDR_W(ADDR_W),
        .LANES(LANES)
    ) u_lut (
        .clk(clk),
        .clk_en(ctrl_reg.clock_en),
        .host_we(host_we),
        .host_addr(ocp_req.maddr[ADDR_W-1:0]),
        .host_wdata(ocp_req.mdata[DATA_W-1:0]),
        .host_rdata(host_rdata),
        .pix_addr(pix_addr),
        .pix_rdata(pix_rdata)
    );

    // read data selection, sampled into sdata_reg on the accept cycle
    always_comb begin
        read_mux = 8'h00;
        if (is_table) begin
            if (!ctrl_reg.mode_status) begin
                read_mux = {2'h0, host_rdata};
            end else begin
                read_mux = 8'h00;
            end
        end else if (is_ctrl) begin
            read_mux = {4'h0, ctrl_reg};
        end else if (is_rev) begin
            read_mux = REVISION;
        end
    end

    // bus slave: the launch cycle lets the memory register its read data
    always_comb begin
        bus_state_next = bus_state_reg;
        sresp_next = `PDC_RESP_NULL;
        sdata_next = sdata_reg;
        case (bus_state_reg)
            PDC_BUS_LAUNCH: begin
                if (cmd_valid) begin
                    bus_state_next = PDC_BUS_ACCEPT;
                end
            end
            PDC_BUS_ACCEPT: begin
                bus_state_next = PDC_BUS_LAUNCH;
                if (cmd_valid) begin
                    sresp_next = `PDC_RESP_DVA;
                    if (cmd_rd) begin
                        sdata_next = read_mux;
                    end
                end
            end
            default: begin
                bus_state_next = PDC_BUS_LAUNCH;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_state_reg <= PDC_BUS_LAUNCH;
            sresp_reg <= `PDC_RESP_NULL;
            sdata_reg <= 8'h00;
        end else begin
            bus_state_reg <= bus_state_next;
            sresp_reg <= sresp_next;
            sdata_reg <= sdata_next;
        end
    end

    // low in reset because the state register resets to launch
    assign scmdaccept = (bus_state_reg == PDC_BUS_ACCEPT) & cmd_valid;
    assign sresp = sresp_reg;
    assign sdata_out = sdata_reg;

    // control register and mode switch
    always_comb begin
        ctrl_next = ctrl_reg;
        if (scmdaccept && cmd_wr && is_ctrl) begin
            ctrl_next.mode_set = ocp_req.mdata[`PDC_CTRL_MODE_SET];
            ctrl_next.clock_en = ocp_req.mdata[`PDC_CTRL_CLOCK_EN];
            ctrl_next.frame_sync_polarity = ocp_req.mdata[`PDC_CTRL_POLARITY];
        end
        // the copy uses the request standing before any same-cycle write
        if (edge_hit) begin
            ctrl_next.mode_status = ctrl_reg.mode_set;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= `PDC_CTRL_RESET;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    // frame sync sampling
    always_comb begin
        fs_s1_next = frame_sync_in;
        fs_s2_next = fs_s1_reg;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fs_s1_reg <= 1'b0;
            fs_s2_reg <= 1'b0;
        end else begin
            fs_s1_reg <= fs_s1_next;
            fs_s2_reg <= fs_s2_next;
        end
    end

    // pixel output; mode_status is zero in reset so the pass-through shows then
    always_comb begin
        if (ctrl_reg.mode_status) begin
            pixel_out = {red_word[5:1], green_word, blue_word[5:1]};
            red_lsb = red_word[0];
            blue_lsb = blue_word[0];
        end else begin
            pixel_out = pixel_in;
            red_lsb = pixel_in[`PDC_RED_HI];
            blue_lsb = pixel_in[`PDC_BLUE_HI];
        end
    end

    // checks

    sequence seq_read_launch;
        bus_state_reg == PDC_BUS_LAUNCH && cmd_rd;
    endsequence

    sequence seq_read_accept;
        scmdaccept && cmd_rd;
    endsequence

    sequence seq_table_read_18;
        seq_read_accept ##0 is_table && ctrl_reg.mode_status;
    endsequence

    property prop_accept_then_resp;
        @(posedge clk) disable iff (!rst_n)
        scmdaccept |=> sresp == `PDC_RESP_DVA && !scmdaccept;
    endproperty

    AST_ACCEPT_RESP: assert property (prop_accept_then_resp)
        else $error("accepted command not answered next cycle");

    AST_RESP_CAUSE: assert property (@(posedge clk) disable iff (!rst_n)
        sresp == `PDC_RESP_DVA |-> $past(scmdaccept))
        else $error("response without an accepted command");

    AST_READ_TWO_CYCLES: assert property (@(posedge clk) disable iff (!rst_n)
        seq_read_launch ##1 cmd_rd |-> scmdaccept)
        else $error("held read not accepted on the second cycle");

    AST_TABLE_ZERO_18: assert property (@(posedge clk) disable iff (!rst_n)
        seq_table_read_18 |=> sdata_out == 8'h00)
        else $error("table read in 18-bit mode not zero");

    AST_TABLE_HIGH_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
        seq_read_accept ##0 is_table |=> sdata_out[7:6] == 2'h0)
        else $error("table read upper bits not zero");

    AST_CTRL_READ: assert property (@(posedge clk) disable iff (!rst_n)
        seq_read_accept ##0 is_ctrl |=>
        sdata_out == {4'h0, $past(ctrl_reg)})
        else $error("control read value wrong");

    AST_REV_READ: assert property (@(posedge clk) disable iff (!rst_n)
        seq_read_accept ##0 is_rev |=> sdata_out == REVISION)
        else $error("revision read value wrong");

    AST_NO_WRITE_18: assert property (@(posedge clk) disable iff (!rst_n)
        ctrl_reg.mode_status |-> !host_we)
        else $error("table written in 18-bit mode");

    AST_MODE_ONLY_AT_EDGE: assert property (@(posedge clk) disable iff (!rst_n)
        $changed(ctrl_reg.mode_status) |-> $past(edge_hit))
        else $error("mode changed without a frame sync edge");

    AST_MODE_COPY: assert property (@(posedge clk) disable iff (!rst_n)
        edge_hit |=> ctrl_reg.mode_status == $past(ctrl_reg.mode_set))
        else $error("mode not copied at frame sync edge");

    AST_EDGE_POLARITY: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(fs_s2_reg) && !$past(ctrl_reg.frame_sync_polarity) |-> $past(edge_hit))
        else $error("rising sync edge missed");

    AST_EDGE_FALLING: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(fs_s2_reg) && $past(ctrl_reg.frame_sync_polarity) |-> $past(edge_hit))
        else $error("falling sync edge missed");

    // index checks written as base plus index (red, with base zero, as the bare index), apart from the or-based decode
    AST_RED_INDEX: assert property (@(posedge clk) disable iff (!rst_n)
        pix_addr[LANE_RED] == ADDR_W'(pixel_in[`PDC_RED_HI:`PDC_RED_LO]))
        else $error("red table index wrong");

    AST_GREEN_INDEX: assert property (@(posedge clk) disable iff (!rst_n)
        pix_addr[LANE_GREEN] ==
        ADDR_W'(`PDC_GREEN_BASE + pixel_in[`PDC_GREEN_HI:`PDC_GREEN_LO]))
        else $error("green table index wrong");

    AST_BLUE_INDEX: assert property (@(posedge clk) disable iff (!rst_n)
        pix_addr[LANE_BLUE] ==
        ADDR_W'(`PDC_BLUE_BASE + pixel_in[`PDC_BLUE_HI:`PDC_BLUE_LO]))
        else $error("blue table index wrong");

    AST_DATA_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
        !(scmdaccept && cmd_rd) |=> $stable(sdata_out))
        else $error("read data changed without an accepted read");

    AST_CTRL_HIGH_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
        seq_read_accept ##0 is_ctrl |=> sdata_out[7:4] == 4'h0)
        else $error("control read upper bits not zero");

    AST_ACCEPT_AFTER_LAUNCH: assert property (@(posedge clk) disable iff (!rst_n)
        scmdaccept |-> $past(cmd_valid) && $past(bus_state_reg) == PDC_BUS_LAUNCH)
        else $error("command accepted without a launch cycle");

    // no disable here: this one watches the outputs while reset is held
    AST_RESET_OUTPUTS: assert property (@(posedge clk)
        !rst_n |-> pixel_out == pixel_in && red_lsb == pixel_in[`PDC_RED_HI]
        && blue_lsb == pixel_in[`PDC_BLUE_HI] && !scmdaccept
        && sresp == `PDC_RESP_NULL && sdata_out == 8'h00)
        else $error("outputs wrong while reset is held");

    AST_PASS_THROUGH: assert property (@(posedge clk) disable iff (!rst_n)
        !ctrl_reg.mode_status |->
        pixel_out == pixel_in && red_lsb == pixel_in[`PDC_RED_HI]
        && blue_lsb == pixel_in[`PDC_BLUE_HI])
        else $error("16-bit pass-through mapping broken");

    AST_CTRL_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
        scmdaccept && cmd_wr && is_ctrl && !edge_hit |=>
        ctrl_reg.mode_set == $past(ocp_req.mdata[`PDC_CTRL_MODE_SET])
        && ctrl_reg.clock_en == $past(ocp_req.mdata[`PDC_CTRL_CLOCK_EN])
        && ctrl_reg.mode_status == $past(ctrl_reg.mode_status))
        else $error("control write not stored as expected");
endmodule

// ---- inc/pdc_defines.svh ----
// address map, field positions, codes and reset values of the pixel depth converter
`ifndef PDC_DEFINES_SVH
`define PDC_DEFINES_SVH

// transfer commands on the 3-bit command field
`define PDC_CMD_IDLE 3'h0
`define PDC_CMD_WR 3'h1
`define PDC_CMD_RD 3'h2

// response codes
`define PDC_RESP_NULL 2'h0
`define PDC_RESP_DVA 2'h1

// register map (byte addresses on the 8-bit address bus)
`define PDC_CTRL_ADDR 8'h80
`define PDC_REV_ADDR 8'h84
`define PDC_TABLE_SEL_BIT 7

// table bases inside the 128-word lookup memory
`define PDC_RED_BASE 7'h00
`define PDC_BLUE_BASE 7'h20
`define PDC_GREEN_BASE 7'h40

// converter_control fields
`define PDC_CTRL_MODE_SET 0
`define PDC_CTRL_MODE_STATUS 1
`define PDC_CTRL_CLOCK_EN 2
`define PDC_CTRL_POLARITY 3
`define PDC_CTRL_RESET 4'h0

// pixel field positions
`define PDC_RED_HI 15
`define PDC_RED_LO 11
`define PDC_GREEN_HI 10
`define PDC_GREEN_LO 5
`define PDC_BLUE_HI 4
`define PDC_BLUE_LO 0

// revision value, arbitrary
`define PDC_REVISION 8'h01

`endif

// ---- inc/pdc_pkg.sv ----
// types shared by the pixel depth converter modules
package pdc_pkg;

    // one command from the bus master
    typedef struct packed {
        logic [2:0] mcmd;
        logic [7:0] maddr;
        logic [7:0] mdata;
    } pdc_ocp_req_t;

    // converter_control as held in flip-flops
    typedef struct packed {
        logic frame_sync_polarity;
        logic clock_en;
        logic mode_status;
        logic mode_set;
    } pdc_ctrl_t;

    // bus slave phases
    typedef enum logic [0:0] {
        PDC_BUS_LAUNCH,
        PDC_BUS_ACCEPT
    } pdc_bus_state_t;

endpackage

// ---- rtl/pdc_lut_mem.sv ----
// lookup memory: one host read/write port and several pixel read lanes
`timescale 1ns/1ps
module pdc_lut_mem
    import pdc_pkg::*;
#(
    parameter int DATA_W = 6,
    parameter int DEPTH = 128,
    parameter int ADDR_W = 7,
    parameter int LANES = 3
) (
    // clock and gate
    input wire logic clk,
    input wire logic clk_en,
    // host port
    input wire logic host_we,
    input wire logic [ADDR_W-1:0] host_addr,
    input wire logic [DATA_W-1:0] host_wdata,
    output logic [DATA_W-1:0] host_rdata,
    // pixel read lanes
    input wire logic [LANES-1:0][ADDR_W-1:0] pix_addr,
    output logic [LANES-1:0][DATA_W-1:0] pix_rdata
);
    logic [DATA_W-1:0] mem [DEPTH];

    // clk_en stands in for the stopped table clock: nothing moves while it is low
    always_ff @(posedge clk) begin
        if (clk_en) begin
            if (host_we) begin
                mem[host_addr] <= host_wdata;
            end
            host_rdata <= mem[host_addr];
        end
    end

    for (genvar i = 0; i < LANES; i++) begin : g_lane
        always_ff @(posedge clk) begin
            if (clk_en) begin
                pix_rdata[i] <= mem[pix_addr[i]];
            end
        end
    end
endmodule

// ---- bench/pdc_lcd_model.sv ----
// lcd controller model: drives the pixel stream and the frame sync level
`timescale 1ns/1ps
module pdc_lcd_model (
    // clock
    input wire logic clk,
    // lcd stream
    output logic [15:0] pixel,
    output logic frame_sync
);
    initial begin
        pixel = 16'h0000;
        frame_sync = 1'b0;
    end
    // changes land on the falling edge, clear of the sampling edge
    task automatic show_pixel(input logic [15:0] px);
        @(negedge clk);
        pixel = px;
    endtask
    // held long enough for the two-stage sampler and the mode flop to settle
    task automatic sync_level(input logic lvl);
        @(negedge clk);
        frame_sync = lvl;
        repeat (4) @(negedge clk);
    endtask
endmodule

// ---- bench/lcd_pixel_depth_converter_test.sv ----
// self-checking bench for the pixel depth converter
`timescale 1ns/1ps
`include "pdc_defines.svh"
module lcd_pixel_depth_converter_test
    import pdc_pkg::*;
();
    // design signals
    logic clk;
    logic rst_n;
    pdc_ocp_req_t ocp_req;
    logic [7:0] sdata_out;
    logic scmdaccept;
    logic [1:0] sresp;
    logic [15:0] pixel_in;
    logic frame_sync_in;
    logic [15:0] pixel_out;
    logic red_lsb;
    logic blue_lsb;
    int mismatches;
    int n_compared;
    logic [15:0] px;

    pdc_converter pdc_converter_i (
        .clk(clk), .rst_n(rst_n), .ocp_req(ocp_req), .sdata_out(sdata_out),
        .scmdaccept(scmdaccept), .sresp(sresp), .pixel_in(pixel_in),
        .frame_sync_in(frame_sync_in), .pixel_out(pixel_out), .red_lsb(red_lsb),
        .blue_lsb(blue_lsb)
    );
    pdc_lcd_model pdc_lcd_model_i (.clk(clk), .pixel(pixel_in), .frame_sync(frame_sync_in));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [17:0] seen, input logic [17:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic finish_test();
        if (mismatches == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // one single-byte command, held until accepted
    task automatic bus(input logic [2:0] cmd, input logic [7:0] addr, input logic [7:0] wd,
                       output logic [7:0] rd);
        int n;
        @(negedge clk);
        ocp_req = '{mcmd: cmd, maddr: addr, mdata: wd};
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (scmdaccept !== 1'b1 && n < 8);
        if (scmdaccept !== 1'b1) begin
            chk("accept", 18'h0, 18'h1);
            finish_test();
        end else begin
            chk("accept_wait", 18'(n), 18'h1);
            @(negedge clk);
            ocp_req.mcmd = `PDC_CMD_IDLE;
            chk("sresp", 18'(sresp), 18'(`PDC_RESP_DVA));
            chk("accept_drop", 18'(scmdaccept), 18'h0);
            rd = sdata_out;
        end
    endtask

    task automatic wr(input logic [7:0] addr, input logic [7:0] d);
        logic [7:0] v;
        bus(`PDC_CMD_WR, addr, d, v);
    endtask

    task automatic rdchk(input logic [7:0] addr, input logic [7:0] exp, input string nm);
        logic [7:0] v;
        bus(`PDC_CMD_RD, addr, 8'h00, v);
        chk(nm, 18'(v), 18'(exp));
    endtask

    // reads control until the reported mode settles, as software would
    task automatic poll(input logic [7:0] exp);
        logic [7:0] v;
        int n;
        n = 0;
        do begin
            bus(`PDC_CMD_RD, `PDC_CTRL_ADDR, 8'h00, v);
            n++;
        end while (v !== exp && n < 8);
        chk("mode_poll", 18'(v), 18'(exp));
        if (v !== exp) begin
            finish_test();
        end
    endtask

    // a code outside idle, read and write is neither accepted nor answered
    task automatic t_badcmd();
        @(negedge clk);
        ocp_req = '{mcmd: 3'h3, maddr: `PDC_CTRL_ADDR, mdata: 8'h01};
        repeat (3) begin
            @(negedge clk);
            chk("bad_cmd", {15'h0, scmdaccept, sresp}, 18'h0);
        end
        ocp_req.mcmd = `PDC_CMD_IDLE;
        rdchk(`PDC_CTRL_ADDR, 8'h04, "bad_cmd_ctrl");
    endtask

    task automatic t_reset();
        pdc_lcd_model_i.show_pixel(16'h8C10);
        @(negedge clk);
        chk("rst_pix", {pixel_out, red_lsb, blue_lsb}, {16'h8C10, 2'b11});
        chk("rst_bus", {7'h0, sdata_out, scmdaccept, sresp}, 18'h0);
    endtask

    task automatic t_regs();
        rdchk(`PDC_CTRL_ADDR, 8'h00, "ctrl_rst");
        wr(`PDC_REV_ADDR, 8'h5A);
        rdchk(`PDC_REV_ADDR, `PDC_REVISION, "rev");
        wr(`PDC_CTRL_ADDR, 8'hF6);
        rdchk(`PDC_CTRL_ADDR, 8'h04, "ctrl_ro");
        wr(8'h81, 8'hFF);
        rdchk(8'h81, 8'h00, "unmapped");
    endtask

    // red idx 5, green idx 2A, blue idx 11; upper bits written high must vanish
    task automatic t_tables();
        wr(8'h05, 8'hEB);
        wr(8'h6A, 8'h55);
        wr(8'h31, 8'hB6);
        wr(8'h25, 8'h01);
        rdchk(8'h05, 8'h2B, "red");
        rdchk(8'h6A, 8'h15, "green");
        rdchk(8'h31, 8'h36, "blue");
        rdchk(8'h25, 8'h01, "blue_alias");
    endtask

    task automatic t_mode18();
        px = {5'h05, 6'h2A, 5'h11};
        pdc_lcd_model_i.show_pixel(px);
        wr(`PDC_CTRL_ADDR, 8'h0D);
        pdc_lcd_model_i.sync_level(1'b1);
        rdchk(`PDC_CTRL_ADDR, 8'h0D, "no_rise");
        pdc_lcd_model_i.sync_level(1'b0);
        poll(8'h0F);
        @(negedge clk);
        chk("pix18", {pixel_out, red_lsb, blue_lsb}, {5'h15, 6'h15, 5'h1B, 2'b10});
        rdchk(8'h05, 8'h00, "rd18");
        wr(8'h05, 8'h00);
        pdc_lcd_model_i.show_pixel(16'h0000);
        pdc_lcd_model_i.show_pixel(px);
        @(negedge clk);
        chk("pix18b", {pixel_out, red_lsb, blue_lsb}, {5'h15, 6'h15, 5'h1B, 2'b10});
        pdc_lcd_model_i.sync_level(1'b1);
    endtask

    task automatic t_mode16();
        wr(`PDC_CTRL_ADDR, 8'h04);
        pdc_lcd_model_i.sync_level(1'b0);
        rdchk(`PDC_CTRL_ADDR, 8'h06, "no_fall");
        pdc_lcd_model_i.sync_level(1'b1);
        poll(8'h04);
        chk("pix16", {pixel_out, red_lsb, blue_lsb}, {px, px[15], px[4]});
        rdchk(8'h05, 8'h2B, "kept");
    endtask

    // writes with the table clock stopped are lost
    task automatic t_gate();
        wr(`PDC_CTRL_ADDR, 8'h00);
        wr(8'h05, 8'h11);
        wr(`PDC_CTRL_ADDR, 8'h04);
        rdchk(8'h05, 8'h2B, "gated");
    endtask

    initial begin
        rst_n = 1'b0;
        ocp_req = '0;
        mismatches = 0;
        n_compared = 0;
        px = 16'h0000;
        t_reset();
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        t_regs();
        t_tables();
        t_mode18();
        t_mode16();
        t_gate();
        t_badcmd();
        finish_test();
    end
endmodule
